//--- rtl/mte_eval.sv
// motion sector combining and twilight level evaluation
//
// Behaviour
// - OR assigned PIR sectors into motion
// - brightness from internal, external or combined
// - combined weighting in five percent steps
// - brightness independent: idle motion starts detection
// - dependent: accept PIR motion only below level
// - level 10 to 2000 lux, default 500
// - download overwrite option clears override
// - no override yet: configured level used
// - preset object sets level, survives power loss
// - level feedback passive or sent on change
// - main unit: external motion above level
// - single device: external motion above level
// - teach captures effective brightness as level
// - teach polarity; opposite value restores configured
// - extension has no outputs, detector one
// - operating mode byte output telegram
module mte_eval import mte_pkg::*; (
  // clock and resets
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic nvRst_n,
  // motion sensing
  input wire logic [SECTOR_COUNT-1:0] pirSector,
  input wire logic [SECTOR_COUNT-1:0] sectorAssign,
  input wire logic extMotion,
  // brightness sensing
  input wire logic [15:0] intBright,
  input wire logic extBrightValid,
  input wire logic [15:0] extBright,
  // configuration
  input wire logic [1:0] appType,
  input wire logic [1:0] brightSrc,
  input wire logic [4:0] weightSel,
  input wire logic brightDep,
  input wire logic extEvalAlways,
  input wire logic [15:0] cfgLevel,
  input wire logic overwriteOnDl,
  input wire logic presetEn,
  input wire logic teachEn,
  input wire logic [1:0] teachPol,
  input wire logic fbActive,
  input wire logic [7:0] fbDelay,
  input wire logic out1OpMode,
  input wire logic [7:0] roomMode,
  // bus events
  input wire logic download,
  input wire logic presetValid,
  input wire logic [15:0] presetLevel,
  input wire logic teachValid,
  input wire logic teachBit,
  // detection results
  output logic motionDetected,
  output logic detectStart,
  output logic [15:0] effBrightness,
  // output functions
  output logic outputsAvail,
  output logic output2Avail,
  output logic opModeTx,
  output logic [7:0] opModeByte,
  // level feedback
  output logic [15:0] levelFb,
  output logic levelFbSend
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mte_det_st_t det;
    logic detStart;
    logic opModeTx;
    logic [7:0] opModeByte;
    logic [15:0] fbLevel;
    logic [15:0] lastLevel;
    logic fbPend;
    logic [7:0] fbCnt;
    logic fbSend;
    logic booted;
  } mte_eval_state_t;

  mte_eval_state_t s_q, s_d;

  logic [15:0] effBright;
  logic ovValid;
  logic [15:0] ovLevel;
  logic localMotion;
  logic [15:0] cfgLevelC;
  logic [15:0] activeLevel;
  logic below;
  logic motionAcc;
  logic extAcc;
  logic teachAct;
  logic teachRel;
  logic presetAct;
  logic storeWr;
  logic storeClr;
  logic [15:0] storeLevel;
  logic fbTrigger;

  function automatic logic [7:0] roomModeByte(input logic [7:0] sel);
    case (sel)
      RMODE_COMFORT: return RMODE_COMFORT;
      RMODE_STANDBY: return RMODE_STANDBY;
      RMODE_NIGHT: return RMODE_NIGHT;
      RMODE_PROTECT: return RMODE_PROTECT;
      default: return RMODE_AUTO;
    endcase
  endfunction

  // ----------------------------------------
  // brightness and level storage
  // ----------------------------------------
  mte_weight u_weight (
    .core_clk(core_clk),
    .nrst(nrst),
    .brightSrc(brightSrc),
    .weightSel(weightSel),
    .intBright(intBright),
    .extBrightValid(extBrightValid),
    .extBright(extBright),
    .effBright(effBright)
  );

  mte_level_store u_store (
    .core_clk(core_clk),
    .nvRst_n(nvRst_n),
    .wrEn(storeWr),
    .wrLevel(storeLevel),
    .clrEn(storeClr),
    .ovValid(ovValid),
    .ovLevel(ovLevel)
  );

  // ----------------------------------------
  // level selection and gating
  // ----------------------------------------
  assign localMotion = |(pirSector & sectorAssign);
  assign cfgLevelC = clampLevel(cfgLevel);
  assign activeLevel = ovValid ? ovLevel : cfgLevelC;
  assign below = effBright < activeLevel;
  assign motionAcc = localMotion && (!brightDep || below);
  // external motion only for single device and main unit
  assign extAcc = extMotion && (appType == APP_SINGLE || appType == APP_MAIN)
    && (!brightDep || extEvalAlways || below);

  // ----------------------------------------
  // override updates
  // ----------------------------------------
  assign teachAct = teachEn && teachValid
    && (teachPol == TPOL_BOTH || teachBit == (teachPol == TPOL_ONE));
  assign teachRel = teachEn && teachValid && teachPol != TPOL_BOTH && !teachAct;
  assign presetAct = presetEn && presetValid;
  // download wins, then teach capture, then preset, then teach release
  assign storeWr = !download && (teachAct || presetAct);
  assign storeLevel = teachAct ? clampLevel(effBright) : clampLevel(presetLevel);
  assign storeClr = (download && overwriteOnDl) || (!download && teachRel && !presetAct);

  // ----------------------------------------
  // outputs available per application
  // ----------------------------------------
  assign outputsAvail = appType != APP_EXTENSION;
  assign output2Avail = appType == APP_SINGLE || appType == APP_MAIN;

  // ----------------------------------------
  // detection and feedback logic
  // ----------------------------------------
  assign fbTrigger = !s_q.booted || download || activeLevel != s_q.lastLevel;

  always_comb begin
    s_d = s_q;
    s_d.detStart = 1'b0;
    s_d.opModeTx = 1'b0;
    s_d.fbSend = 1'b0;
    s_d.booted = 1'b1;
    s_d.lastLevel = activeLevel;
    s_d.fbLevel = activeLevel;
    case (s_q.det)
      DET_IDLE: begin
        if (motionAcc || extAcc) begin
          s_d.det = DET_ACTIVE;
          s_d.detStart = 1'b1;
          if (outputsAvail && out1OpMode) begin
            s_d.opModeTx = 1'b1;
            s_d.opModeByte = roomModeByte(roomMode);
          end
        end
      end
      DET_ACTIVE: begin
        if (!localMotion && !extMotion) begin
          s_d.det = DET_IDLE;
        end
      end
      default: begin
        s_d.det = DET_IDLE;
      end
    endcase
    if (s_q.fbPend) begin
      if (s_q.fbCnt == 8'h00) begin
        s_d.fbSend = 1'b1;
        s_d.fbPend = 1'b0;
      end else begin
        s_d.fbCnt = s_q.fbCnt - 8'h01;
      end
    end
    if (fbTrigger && fbActive) begin
      s_d.fbPend = 1'b1;
      s_d.fbCnt = fbDelay;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{det: DET_IDLE, detStart: 1'b0, opModeTx: 1'b0, opModeByte: RMODE_AUTO,
               fbLevel: LVL_DEF, lastLevel: LVL_DEF, fbPend: 1'b0, fbCnt: 8'h00,
               fbSend: 1'b0, booted: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign motionDetected = s_q.det == DET_ACTIVE;
  assign detectStart = s_q.detStart;
  assign effBrightness = effBright;
  assign opModeTx = s_q.opModeTx;
  assign opModeByte = s_q.opModeByte;
  assign levelFb = s_q.fbLevel;
  assign levelFbSend = s_q.fbSend;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_idle_free_motion;
    !motionDetected && localMotion && !brightDep;
  endsequence

  sequence s_bright_idle;
    !motionDetected && brightDep && !below && !extMotion;
  endsequence

  property p_sector_or;
    @(posedge core_clk) disable iff (!nrst)
    s_idle_free_motion |=> motionDetected && detectStart;
  endproperty
  a_sector_or: assert property (p_sector_or) else $error("assigned sector motion not detected");

  property p_dark_gate;
    @(posedge core_clk) disable iff (!nrst)
    s_bright_idle |=> !detectStart && !motionDetected;
  endproperty
  a_dark_gate: assert property (p_dark_gate) else $error("motion accepted above twilight level");

  property p_level_range;
    @(posedge core_clk) disable iff (!nrst)
    s_q.booted |-> levelFb >= LVL_MIN && levelFb <= LVL_MAX;
  endproperty
  a_level_range: assert property (p_level_range) else $error("twilight level out of range");

  property p_dl_clear;
    @(posedge core_clk) disable iff (!nrst)
    download && overwriteOnDl |=> !ovValid ##1 levelFb == $past(cfgLevelC);
  endproperty
  a_dl_clear: assert property (p_dl_clear) else $error("download did not restore level");

  property p_dl_keep;
    @(posedge core_clk) disable iff (!nrst)
    download && !overwriteOnDl && ovValid |=> ovValid && ovLevel == $past(ovLevel);
  endproperty
  a_dl_keep: assert property (p_dl_keep) else $error("download dropped retained level");

  property p_preset;
    @(posedge core_clk) disable iff (!nrst)
    presetAct && !download && !teachAct |=> ovValid && ovLevel == clampLevel($past(presetLevel));
  endproperty
  a_preset: assert property (p_preset) else $error("preset level not taken");

  property p_teach;
    @(posedge core_clk) disable iff (!nrst)
    teachAct && !download |=> ovValid && ovLevel == clampLevel($past(effBright));
  endproperty
  a_teach: assert property (p_teach) else $error("teach did not capture brightness");

  property p_teach_rel;
    @(posedge core_clk) disable iff (!nrst)
    teachRel && !download && !presetAct |=> !ovValid;
  endproperty
  a_teach_rel: assert property (p_teach_rel) else $error("opposite teach value did not restore");

  property p_fb_send;
    @(posedge core_clk) disable iff (!nrst)
    fbActive && download && fbDelay == 8'h00 |-> ##2 levelFbSend;
  endproperty
  a_fb_send: assert property (p_fb_send) else $error("feedback not sent after download");

  property p_fb_passive;
    @(posedge core_clk) disable iff (!nrst)
    !fbActive ##1 !fbActive ##1 !fbActive |-> !levelFbSend;
  endproperty
  a_fb_passive: assert property (p_fb_passive) else $error("passive feedback was sent");

  property p_ext_ignore;
    @(posedge core_clk) disable iff (!nrst)
    extMotion && !localMotion && brightDep && !extEvalAlways && !below && !motionDetected
      |=> !motionDetected;
  endproperty
  a_ext_ignore: assert property (p_ext_ignore) else $error("external motion above level accepted");

  property p_ext_always;
    @(posedge core_clk) disable iff (!nrst)
    extMotion && extEvalAlways && appType == APP_SINGLE && !motionDetected |=> detectStart;
  endproperty
  a_ext_always: assert property (p_ext_always) else $error("external motion not evaluated");

  property p_ext_app;
    @(posedge core_clk) disable iff (!nrst)
    appType == APP_EXTENSION ##1 appType == APP_EXTENSION |-> !opModeTx && !outputsAvail;
  endproperty
  a_ext_app: assert property (p_ext_app) else $error("extension produced output");

  property p_opmode;
    @(posedge core_clk) disable iff (!nrst)
    opModeTx |-> detectStart && opModeByte <= RMODE_PROTECT;
  endproperty
  a_opmode: assert property (p_opmode) else $error("illegal operating mode telegram");

  property p_opmode_off;
    @(posedge core_clk) disable iff (!nrst)
    !out1OpMode |=> !opModeTx;
  endproperty
  a_opmode_off: assert property (p_opmode_off) else $error("operating mode sent while disabled");

  property p_detector_out;
    @(posedge core_clk) disable iff (!nrst)
    appType == APP_DETECTOR |-> outputsAvail && !output2Avail;
  endproperty
  a_detector_out: assert property (p_detector_out) else $error("detector output availability wrong");

  sequence s_fb_due;
    s_q.fbPend && s_q.fbCnt == 8'h00;
  endsequence

  property p_fb_wait;
    @(posedge core_clk) disable iff (!nrst)
    s_q.fbPend && s_q.fbCnt != 8'h00 |=> !levelFbSend;
  endproperty
  a_fb_wait: assert property (p_fb_wait) else $error("feedback sent before delay elapsed");

  property p_fb_due;
    @(posedge core_clk) disable iff (!nrst)
    s_fb_due |=> levelFbSend;
  endproperty
  a_fb_due: assert property (p_fb_due) else $error("feedback not sent after delay");

endmodule

//--- rtl/mte_level_store.sv
// retained twilight level override, kept across bus voltage loss
module mte_level_store import mte_pkg::*; (
  // clock and retention reset
  input wire logic core_clk,
  input wire logic nvRst_n,
  // update requests
  input wire logic wrEn,
  input wire logic [15:0] wrLevel,
  input wire logic clrEn,
  // stored override
  output logic ovValid,
  output logic [15:0] ovLevel
);

  typedef struct packed {
    logic valid;
    logic [15:0] level;
  } mte_store_state_t;

  mte_store_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (wrEn) begin
      s_d.valid = 1'b1;
      s_d.level = wrLevel;
    end else if (clrEn) begin
      s_d.valid = 1'b0;
    end
  end

  // of the two resets only the retention reset clears it, bus reset does not
  always_ff @(posedge core_clk or negedge nvRst_n) begin
    if (!nvRst_n) begin
      s_q <= '{valid: 1'b0, level: LVL_DEF};
    end else begin
      s_q <= s_d;
    end
  end

  assign ovValid = s_q.valid;
  assign ovLevel = s_q.level;

endmodule

//--- rtl/mte_pkg.sv
// constants and helpers for the motion and twilight evaluation block
package mte_pkg;

  // ----------------------------------------
  // sectors and brightness levels (lux)
  // ----------------------------------------
  localparam int SECTOR_COUNT = 3;
  localparam logic [15:0] LVL_MIN = 16'h000a;
  localparam logic [15:0] LVL_DEF = 16'h01f4;
  localparam logic [15:0] LVL_MAX = 16'h07d0;

  // ----------------------------------------
  // weighting, internal share in percent
  // ----------------------------------------
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_TOP = 7'h5f;
  localparam logic [6:0] PCT_STEP = 7'h05;
  localparam logic [4:0] WSEL_MAX = 5'h12;

  // ----------------------------------------
  // configuration encodings
  // ----------------------------------------
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_COMB = 2'h2;
  localparam logic [1:0] APP_SINGLE = 2'h0;
  localparam logic [1:0] APP_MAIN = 2'h1;
  localparam logic [1:0] APP_EXTENSION = 2'h2;
  localparam logic [1:0] APP_DETECTOR = 2'h3;
  localparam logic [1:0] TPOL_ONE = 2'h0;
  localparam logic [1:0] TPOL_ZERO = 2'h1;
  localparam logic [1:0] TPOL_BOTH = 2'h2;

  // ----------------------------------------
  // room controller operating mode byte
  // ----------------------------------------
  localparam logic [7:0] RMODE_AUTO = 8'h00;
  localparam logic [7:0] RMODE_COMFORT = 8'h01;
  localparam logic [7:0] RMODE_STANDBY = 8'h02;
  localparam logic [7:0] RMODE_NIGHT = 8'h03;
  localparam logic [7:0] RMODE_PROTECT = 8'h04;

  // ----------------------------------------
  // detection states and reset values
  // ----------------------------------------
  typedef enum logic [1:0] {
    DET_IDLE = 2'h1,
    DET_ACTIVE = 2'h2
  } mte_det_st_t;

  localparam logic [15:0] EXT_RESET = 16'h0000;

  function automatic logic [15:0] clampLevel(input logic [15:0] lux);
    if (lux < LVL_MIN) begin
      return LVL_MIN;
    end else if (lux > LVL_MAX) begin
      return LVL_MAX;
    end else begin
      return lux;
    end
  endfunction

endpackage

//--- rtl/mte_weight.sv
// brightness source selection and weighted mix
module mte_weight import mte_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // configuration
  input wire logic [1:0] brightSrc,
  input wire logic [4:0] weightSel,
  // brightness inputs
  input wire logic [15:0] intBright,
  input wire logic extBrightValid,
  input wire logic [15:0] extBright,
  // result
  output logic [15:0] effBright
);

  typedef struct packed {
    logic [15:0] ext;
    logic [15:0] eff;
  } mte_weight_state_t;

  mte_weight_state_t s_q, s_d;
  logic [4:0] sel;
  logic [6:0] pctInt;
  logic [23:0] mix;

  always_comb begin
    s_d = s_q;
    sel = (weightSel > WSEL_MAX) ? WSEL_MAX : weightSel;
    pctInt = 7'(PCT_TOP - 7'(sel * PCT_STEP));
    mix = (24'(intBright) * 24'(pctInt) + 24'(s_q.ext) * 24'(PCT_FULL - pctInt)) / 24'(PCT_FULL);
    if (extBrightValid) begin
      s_d.ext = extBright;
    end
    case (brightSrc)
      SRC_INT: s_d.eff = intBright;
      SRC_EXT: s_d.eff = s_q.ext;
      SRC_COMB: s_d.eff = mix[15:0];
      default: s_d.eff = intBright;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{ext: EXT_RESET, eff: EXT_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign effBright = s_q.eff;

  property p_int_pass;
    @(posedge core_clk) disable iff (!nrst)
    brightSrc == SRC_INT |=> effBright == $past(intBright);
  endproperty
  a_int_pass: assert property (p_int_pass) else $error("internal brightness not passed");

endmodule

//--- test/mte_bus_peer.sv
// stand-in for the other bus devices that send telegrams to the block
module mte_bus_peer (
  // clock
  input wire logic core_clk,
  // telegrams towards the block
  output logic extMotion = 1'b0,
  output logic extBrightValid = 1'b0,
  output logic [15:0] extBright = 16'h0000,
  output logic presetValid = 1'b0,
  output logic [15:0] presetLevel = 16'h0000,
  output logic teachValid = 1'b0,
  output logic teachBit = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // telegram senders
  // ----------------------------------------
  // one-cycle telegram; payload scrambled once valid drops
  task automatic send(input int kind, input logic [15:0] val);
    @(negedge core_clk);
    if (kind == 0) begin
      extBright = val;
      extBrightValid = 1'b1;
    end else if (kind == 1) begin
      presetLevel = val;
      presetValid = 1'b1;
    end else begin
      teachBit = val[0];
      teachValid = 1'b1;
    end
    @(negedge core_clk);
    extBrightValid = 1'b0;
    presetValid = 1'b0;
    teachValid = 1'b0;
    extBright = ~extBright;
    presetLevel = ~presetLevel;
    teachBit = ~teachBit;
  endtask

  task automatic setMotion(input logic v);
    @(negedge core_clk);
    extMotion = v;
  endtask
endmodule

//--- test/test_motion_twilight_evaluation.sv
// self-checking bench for the motion and twilight evaluation block
module test_motion_twilight_evaluation import mte_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic nrst, nvRst_n, brightDep, extEvalAlways, overwriteOnDl, presetEn, teachEn;
  logic fbActive, out1OpMode, download, extMotion, extBrightValid, presetValid, teachValid, teachBit;
  logic [2:0] pirSector, sectorAssign;
  logic [15:0] intBright, extBright, cfgLevel, presetLevel, effBrightness, levelFb;
  logic [1:0] appType, brightSrc, teachPol;
  logic [4:0] weightSel;
  logic [7:0] fbDelay, roomMode, opModeByte;
  logic motionDetected, detectStart, outputsAvail, output2Avail, opModeTx, levelFbSend;
  int errCount = 0;
  int checked = 0;
  int starts = 0;
  int txs = 0;
  int sends = 0;
  int extM = 0;
  int s0;

  always #50 core_clk = ~core_clk;

  always @(negedge core_clk) begin
    if (detectStart === 1'b1) starts++;
    if (opModeTx === 1'b1) txs++;
    if (levelFbSend === 1'b1) sends++;
  end

  mte_bus_peer u_mte_bus_peer (.core_clk(core_clk), .extMotion(extMotion), .extBrightValid(extBrightValid),
    .extBright(extBright), .presetValid(presetValid), .presetLevel(presetLevel), .teachValid(teachValid),
    .teachBit(teachBit));

  mte_eval u_mte_eval (.core_clk(core_clk), .nrst(nrst), .nvRst_n(nvRst_n), .pirSector(pirSector),
    .sectorAssign(sectorAssign), .extMotion(extMotion), .intBright(intBright), .extBrightValid(extBrightValid),
    .extBright(extBright), .appType(appType), .brightSrc(brightSrc), .weightSel(weightSel),
    .brightDep(brightDep), .extEvalAlways(extEvalAlways), .cfgLevel(cfgLevel), .overwriteOnDl(overwriteOnDl),
    .presetEn(presetEn), .teachEn(teachEn), .teachPol(teachPol), .fbActive(fbActive), .fbDelay(fbDelay),
    .out1OpMode(out1OpMode), .roomMode(roomMode), .download(download), .presetValid(presetValid),
    .presetLevel(presetLevel), .teachValid(teachValid), .teachBit(teachBit), .motionDetected(motionDetected),
    .detectStart(detectStart), .effBrightness(effBrightness), .outputsAvail(outputsAvail),
    .output2Avail(output2Avail), .opModeTx(opModeTx), .opModeByte(opModeByte), .levelFb(levelFb),
    .levelFbSend(levelFbSend));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] effCalc();
    int p;
    p = 95 - 5 * (weightSel > 5'h12 ? 18 : int'(weightSel));
    if (brightSrc == SRC_INT) return intBright;
    if (brightSrc == SRC_EXT) return 16'(extM);
    return 16'((int'(intBright) * p + extM * (100 - p)) / 100);
  endfunction

  task automatic endOfTest();
    if (errCount == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic setInt(input logic [15:0] v);
    intBright = v;
    cyc(3);
  endtask

  task automatic tryMotion(input logic [2:0] pir, input logic ext, input logic acc);
    int n0;
    n0 = starts;
    pirSector = pir;
    u_mte_bus_peer.setMotion(ext);
    cyc(3);
    chk("motionDetected", {15'h0, acc}, {15'h0, motionDetected});
    chk("detectStart count", {15'h0, acc}, 16'(starts - n0));
    pirSector = 3'h0;
    u_mte_bus_peer.setMotion(1'b0);
    cyc(2);
    chk("motionDetected", 16'h0000, {15'h0, motionDetected});
  endtask

  task automatic levelIs(input logic [15:0] v);
    cyc(4);
    chk("levelFb", v, levelFb);
  endtask

  initial begin
    #2000000;
    errCount++;
    endOfTest();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h17ba));
    {nrst, nvRst_n, download, pirSector, intBright, weightSel, brightDep, extEvalAlways} = '0;
    {sectorAssign, appType, brightSrc, overwriteOnDl} = {3'h7, APP_SINGLE, SRC_INT, 1'b0};
    {fbDelay, teachPol} = {8'h00, TPOL_ONE};
    {cfgLevel, presetEn, teachEn, fbActive, out1OpMode, roomMode} = {16'h01f4, 4'hf, 8'h01};
    cyc(20);
    nrst = 1'b1;
    nvRst_n = 1'b1;
    cyc(4);
    chk("levelFb", 16'h01f4, levelFb);
    for (int i = 0; i < 60; i++) begin
      brightSrc = 2'(i / 20);
      weightSel = 5'(i % 20);
      intBright = 16'($urandom_range(3000));
      extM = $urandom_range(3000);
      u_mte_bus_peer.send(0, 16'(extM));
      cyc(4);
      chk("effBrightness", effCalc(), effBrightness);
    end
    brightSrc = SRC_INT;
    setInt(16'h0bb8);
    for (int m = 0; m < 8; m++) begin
      sectorAssign = 3'(m);
      pirSector = 3'($urandom_range(7));
      tryMotion(pirSector, 1'b0, |(pirSector & sectorAssign));
    end
    sectorAssign = 3'h7;
    for (int r = 0; r < 6; r++) begin
      roomMode = 8'(r);
      s0 = txs;
      tryMotion(3'h2, 1'b0, 1'b1);
      chk("opModeByte", r < 5 ? 16'(r) : 16'h0000, {8'h00, opModeByte});
      chk("opModeTx count", 16'h0001, 16'(txs - s0));
    end
    out1OpMode = 1'b0;
    s0 = txs;
    tryMotion(3'h2, 1'b0, 1'b1);
    chk("opModeTx count", 16'h0000, 16'(txs - s0));
    out1OpMode = 1'b1;
    brightDep = 1'b1;
    setInt(16'h01f3);
    tryMotion(3'h4, 1'b0, 1'b1);
    setInt(16'h01f4);
    tryMotion(3'h4, 1'b0, 1'b0);
    setInt(16'h0258);
    for (int a = 0; a < 8; a++) begin
      appType = 2'(a / 2);
      extEvalAlways = a[0];
      cyc(1);
      chk("outputsAvail", {15'h0, appType != APP_EXTENSION}, {15'h0, outputsAvail});
      chk("output2Avail", {15'h0, appType < APP_EXTENSION}, {15'h0, output2Avail});
      tryMotion(3'h0, 1'b1, appType < APP_EXTENSION && a[0]);
    end
    appType = APP_SINGLE;
    cfgLevel = 16'h0005;
    levelIs(16'h000a);
    cfgLevel = 16'h0bb8;
    levelIs(16'h07d0);
    cfgLevel = 16'h01f4;
    levelIs(16'h01f4);
    s0 = sends;
    u_mte_bus_peer.send(1, 16'h0320);
    levelIs(16'h0320);
    chk("levelFbSend count", 16'h0001, 16'(sends - s0));
    presetEn = 1'b0;
    u_mte_bus_peer.send(1, 16'h0384);
    levelIs(16'h0320);
    nrst = 1'b0;
    cyc(2);
    s0 = sends;
    nrst = 1'b1;
    levelIs(16'h0320);
    cyc(2);
    chk("levelFbSend count", 16'h0001, 16'(sends - s0));
    download = 1'b1;
    cyc(1);
    download = 1'b0;
    levelIs(16'h0320);
    overwriteOnDl = 1'b1;
    download = 1'b1;
    cyc(1);
    download = 1'b0;
    levelIs(16'h01f4);
    for (int p = 0; p < 3; p++) begin
      teachPol = 2'(p);
      setInt(16'(1000 + 100 * p));
      u_mte_bus_peer.send(2, {15'h0, p != 1});
      levelIs(16'(1000 + 100 * p));
      setInt(16'h012c);
      u_mte_bus_peer.send(2, {15'h0, p == 1});
      levelIs(p == 2 ? 16'h012c : 16'h01f4);
    end
    teachEn = 1'b0;
    setInt(16'h05dc);
    u_mte_bus_peer.send(2, 16'h0001);
    levelIs(16'h012c);
    fbActive = 1'b0;
    presetEn = 1'b1;
    s0 = sends;
    u_mte_bus_peer.send(1, 16'h0258);
    levelIs(16'h0258);
    chk("levelFbSend count", 16'h0000, 16'(sends - s0));
    fbActive = 1'b1;
    fbDelay = 8'h05;
    cyc(2);
    s0 = sends;
    u_mte_bus_peer.send(1, 16'h02bc);
    levelIs(16'h02bc);
    chk("levelFbSend count", 16'h0000, 16'(sends - s0));
    cyc(4);
    chk("levelFbSend count", 16'h0001, 16'(sends - s0));
    endOfTest();
  end
endmodule
